// File: hdl/csp_defs.vh
`ifndef CSP_DEFS_VH
`define CSP_DEFS_VH

// Register byte addresses, and word indexes of the request maps
`define CSP_ADDR_PWRDN_MODE 8'h00
`define CSP_ADDR_CPU_CFG    8'h04
`define CSP_ADDR_BUS_CFG    8'h08
`define CSP_ADDR_STATUS     8'h0c
`define CSP_IDX_REQ_MAP0    8'h0a
`define CSP_IDX_REQ_MAP1    8'h0b
`define CSP_ADDR_REQ_MAP0   (`CSP_IDX_REQ_MAP0 << 2)
`define CSP_ADDR_REQ_MAP1   (`CSP_IDX_REQ_MAP1 << 2)

// Field positions
`define CSP_CPU_STOPPABLE_POS 0
`define CSP_CPU_TRISTATE_POS  8
`define CSP_BUS_FREE_POS      0
`define CSP_LINK_FREE_POS     8
`define CSP_REQ_MODE_POS      16
`define CSP_ST_STATE_POS      0
`define CSP_ST_OSC_POS        5
`define CSP_ST_CPU_STOP_POS   6
`define CSP_ST_BUS_STOP_POS   7
`define CSP_ST_REQ_POS        8
`define CSP_ST_DIFF_RUN_POS   16
`define CSP_ST_BUS_RUN_POS    24

// Reset values
`define CSP_RST_PWRDN_MODE 32'h0000_0000
`define CSP_RST_CPU_CFG    32'h0000_0003
`define CSP_RST_BUS_CFG    32'h0000_0000
`define CSP_RST_REQ_MAP    32'h0000_0000

// Timing
`define CSP_CLK_MHZ       125
`define CSP_LOCK_TIME_US  1800
`define CSP_LOCK_CYC      (`CSP_LOCK_TIME_US * `CSP_CLK_MHZ)

`endif

// File: hdl/csp_clock_stop_ctrl.v
// Implementation choices: the placing of the registers and the APB slave port.
`include "csp_defs.vh"

// Functional notes
// - Shared pin: supply-good first, then power-down
// - Synchronize power-down; stop outputs before oscillator off
// - Two high samples stop single-ended outputs low
// - Differential outputs stop within four periods
// - Power-down drive-mode bit selects held-high or tristate
// - Stable clocks within lock time after release
// - Tristated link outputs, and processor outputs with tristate bit set, driven high after release
// - All outputs enabled together after lock; each output starts on the first rising edge of its own divider
// - Processor stop after sampled processor-clock edges
// - Stopped processor output rests tristated
// - Processor outputs restart synchronously without runt pulses
// - Tristate bit set drives released output high
// - Free-running outputs ignore bus stop
// - Bus stop latches bus clocks low and tristates stoppable link outputs
// - Bus stop release restarts glitch-free, one clock
// - Stoppable link outputs driven high after release
// - Map registers choose outputs for each request
// - Requests debounced over two reference edges
// - Request release resumes outputs together glitch-free
// - Tristate request mode drives released outputs high
// - Request stops outputs; mode picks final drive
module csp_clock_stop_ctrl #(
  parameter       NCPU     = 2,
  parameter       NSRC     = 6,
  parameter       NBUS     = 6,
  parameter       NFREE    = 2,
  parameter       NREQ     = 2,
  parameter [7:0] CPU_HALF = 8'h01,
  parameter [7:0] LINK_HALF = 8'h02,
  parameter [7:0] BUS_HALF = 8'h04,
  parameter       LCW      = 18,
  parameter [LCW-1:0] LOCK_CYC = `CSP_LOCK_CYC
) (
  input  wire                 clk_sys,
  input  wire                 arst_n,
  input  wire                 clk_en,
  input  wire                 psel,
  input  wire                 penable,
  input  wire                 pwrite,
  input  wire [7:0]           paddr,
  input  wire [31:0]          pwdata,
  output reg  [31:0]          prdata,
  output wire                 pready,
  output wire                 pslverr,
  input  wire                 supply_good_strobe_n,
  input  wire                 processor_clock_stop_n,
  input  wire                 bus_clock_stop_n,
  input  wire [NREQ-1:0]      clock_request_n,
  output reg                  osc_enable,
  output reg                  vco_enable,
  output reg  [NCPU+NSRC-1:0] diff_true,
  output reg  [NCPU+NSRC-1:0] diff_true_oe,
  output reg  [NCPU+NSRC-1:0] diff_comp,
  output reg  [NCPU+NSRC-1:0] diff_comp_oe,
  output reg  [NBUS-1:0]      bus_clk
);

  localparam ND = NCPU + NSRC;
  localparam NS = NREQ + 3;

  localparam [4:0] ST_BOOT = 5'h01;
  localparam [4:0] ST_LOCK = 5'h02;
  localparam [4:0] ST_RUN  = 5'h04;
  localparam [4:0] ST_STOP = 5'h08;
  localparam [4:0] ST_OFF  = 5'h10;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronizers

  reg  [NS-1:0] sync1_reg;
  reg  [NS-1:0] sync2_reg;
  wire [NS-1:0] async_in;

  assign async_in = {clock_request_n, bus_clock_stop_n, processor_clock_stop_n,
                     supply_good_strobe_n};

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sync1_reg <= {NS{1'b1}};
      sync2_reg <= {NS{1'b1}};
    end else if (clk_en) begin
      sync1_reg <= async_in;
      sync2_reg <= sync1_reg;
    end
  end

  // Shared pin: low-active supply good at boot, high-active power-down later
  wire            pin_sync      = sync2_reg[0];
  wire            cpu_stop_sync = ~sync2_reg[1];
  wire            bus_stop_sync = ~sync2_reg[2];
  wire [NREQ-1:0] req_sync      = ~sync2_reg[NS-1:3];

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  reg  [31:0] pwrdn_mode_reg;
  reg  [31:0] cpu_cfg_reg;
  reg  [31:0] bus_cfg_reg;
  reg  [31:0] map0_reg;
  reg  [31:0] map1_reg;
  reg  [31:0] status;
  reg  [31:0] rd_mux;
  reg         addr_hit;
  reg  [4:0]  state_reg;
  reg  [4:0]  state_next;
  reg  [ND-1:0]   diff_run_reg;
  reg  [NBUS-1:0] bus_run_reg;
  reg             cpu_stop_act_reg;
  reg             bus_stop_act_reg;
  reg  [NREQ-1:0] req_act_reg;

  wire acc_phase = psel & penable;
  wire wr_en     = acc_phase & pwrite & clk_en;

  assign pready  = 1'b1;
  assign pslverr = acc_phase & ~addr_hit;

  always @* begin
    status = 32'h0000_0000;
    status[`CSP_ST_STATE_POS+4:`CSP_ST_STATE_POS] = state_reg;
    status[`CSP_ST_OSC_POS] = osc_enable;
    status[`CSP_ST_CPU_STOP_POS] = cpu_stop_act_reg;
    status[`CSP_ST_BUS_STOP_POS] = bus_stop_act_reg;
    status[`CSP_ST_REQ_POS+NREQ-1:`CSP_ST_REQ_POS] = req_act_reg;
    status[`CSP_ST_DIFF_RUN_POS+ND-1:`CSP_ST_DIFF_RUN_POS] = diff_run_reg;
    status[`CSP_ST_BUS_RUN_POS+NBUS-1:`CSP_ST_BUS_RUN_POS] = bus_run_reg;
  end

  always @* begin
    addr_hit = 1'b1;
    rd_mux   = 32'h0000_0000;
    case (paddr)
      `CSP_ADDR_PWRDN_MODE:  rd_mux = pwrdn_mode_reg;
      `CSP_ADDR_CPU_CFG:     rd_mux = cpu_cfg_reg;
      `CSP_ADDR_BUS_CFG:     rd_mux = bus_cfg_reg;
      `CSP_ADDR_STATUS:      rd_mux = status;
      `CSP_ADDR_REQ_MAP0:    rd_mux = map0_reg;
      `CSP_ADDR_REQ_MAP1:    rd_mux = map1_reg;
      default:               addr_hit = 1'b0;
    endcase
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pwrdn_mode_reg <= `CSP_RST_PWRDN_MODE;
      cpu_cfg_reg    <= `CSP_RST_CPU_CFG;
      bus_cfg_reg    <= `CSP_RST_BUS_CFG;
      map0_reg       <= `CSP_RST_REQ_MAP;
      map1_reg       <= `CSP_RST_REQ_MAP;
      prdata      <= 32'h0000_0000;
    end else if (clk_en) begin
      if (psel & ~penable) begin
        prdata <= rd_mux;
      end
      if (wr_en) begin
        case (paddr)
          `CSP_ADDR_PWRDN_MODE:  pwrdn_mode_reg <= pwdata;
          `CSP_ADDR_CPU_CFG:     cpu_cfg_reg <= pwdata;
          `CSP_ADDR_BUS_CFG:     bus_cfg_reg <= pwdata;
          `CSP_ADDR_REQ_MAP0:    map0_reg <= pwdata;
          `CSP_ADDR_REQ_MAP1:    map1_reg <= pwdata;
          default:               pwrdn_mode_reg <= pwrdn_mode_reg;
        endcase
      end
    end
  end

  wire [ND-1:0]    pwrdn_mode    = pwrdn_mode_reg[ND-1:0];
  wire [NCPU-1:0]  cpu_stoppable = cpu_cfg_reg[`CSP_CPU_STOPPABLE_POS+NCPU-1:
                                               `CSP_CPU_STOPPABLE_POS];
  wire [NCPU-1:0]  cpu_tristate  = cpu_cfg_reg[`CSP_CPU_TRISTATE_POS+NCPU-1:
                                               `CSP_CPU_TRISTATE_POS];
  wire [NFREE-1:0] bus_free      = bus_cfg_reg[`CSP_BUS_FREE_POS+NFREE-1:
                                               `CSP_BUS_FREE_POS];
  wire [NSRC-1:0]  link_free     = bus_cfg_reg[`CSP_LINK_FREE_POS+NSRC-1:
                                               `CSP_LINK_FREE_POS];
  wire             req_mode      = bus_cfg_reg[`CSP_REQ_MODE_POS];

  // Outputs governed by the active requests
  wire [NSRC-1:0] req_src = (req_act_reg[0] ? map0_reg[NSRC-1:0] : {NSRC{1'b0}}) |
                            (req_act_reg[NREQ-1] ? map1_reg[NSRC-1:0] : {NSRC{1'b0}});

  ////////////////////////////////////////////////////////////////////////////
  // Output clock dividers: 0 processor, 1 serial link, 2 bus

  wire [2:0] div_ph;
  wire [2:0] div_rise;
  wire [2:0] div_fall;

  genvar k;
  generate
    for (k = 0; k < 3; k = k + 1) begin : g_div
      localparam [7:0] HALF = (k == 0) ? CPU_HALF : (k == 1) ? LINK_HALF : BUS_HALF;
      reg [7:0] cnt_reg;
      reg       ph_reg;
      wire      tick = clk_en & vco_enable & (cnt_reg == 8'h00);
      assign div_ph[k]   = ph_reg;
      assign div_rise[k] = tick & ~ph_reg;
      assign div_fall[k] = tick & ph_reg;
      always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          cnt_reg <= 8'h00;
          ph_reg  <= 1'b0;
        end else if (clk_en) begin
          if (!vco_enable) begin
            cnt_reg <= 8'h00;
            ph_reg  <= 1'b0;
          end else if (tick) begin
            cnt_reg <= HALF - 8'h01;
            ph_reg  <= ~ph_reg;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Power-down sequencing

  reg [1:0]     pwrdn_hits_reg;
  reg [LCW-1:0] lock_cnt_reg;
  reg           pwrdn_stop_reg;

  wire all_stopped = ~|diff_run_reg & ~|bus_run_reg;
  wire pwrdn_seen  = div_fall[0] & pin_sync & pwrdn_hits_reg[0];
  wire lock_done   = (lock_cnt_reg == LOCK_CYC - {{(LCW-1){1'b0}}, 1'b1});
  wire hold_all    = ~state_reg[2];

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_BOOT: if (!pin_sync) state_next = ST_LOCK;
      ST_LOCK: begin
        if (pin_sync) state_next = ST_OFF;
        else if (lock_done) state_next = ST_RUN;
      end
      ST_RUN:  if (pwrdn_seen) state_next = ST_STOP;
      ST_STOP: if (all_stopped) state_next = ST_OFF;
      ST_OFF:  if (!pin_sync) state_next = ST_LOCK;
      default: state_next = ST_BOOT;
    endcase
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_reg    <= ST_BOOT;
      pwrdn_hits_reg <= 2'h0;
      lock_cnt_reg   <= {LCW{1'b0}};
      pwrdn_stop_reg <= 1'b1;
      osc_enable   <= 1'b1;
      vco_enable   <= 1'b1;
    end else if (clk_en) begin
      state_reg  <= state_next;
      osc_enable <= ~state_next[4];
      vco_enable <= ~state_next[4];
      if (div_fall[0]) begin
        pwrdn_hits_reg <= {pwrdn_hits_reg[0], pin_sync & state_reg[2]};
      end
      if (state_next == ST_STOP) begin
        pwrdn_stop_reg <= 1'b1;
      end else if (state_next == ST_LOCK) begin
        pwrdn_stop_reg <= 1'b0;
      end
      if (state_reg[1]) begin
        lock_cnt_reg <= lock_cnt_reg + {{(LCW-1){1'b0}}, 1'b1};
      end else begin
        lock_cnt_reg <= {LCW{1'b0}};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stop request sampling

  reg [1:0]      cpu_samp_reg;
  reg [2*NREQ-1:0] req_samp_reg;

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cpu_samp_reg     <= 2'h0;
      cpu_stop_act_reg <= 1'b0;
      bus_stop_act_reg <= 1'b0;
    end else if (clk_en) begin
      if (div_fall[0]) begin
        cpu_samp_reg <= {cpu_samp_reg[0], cpu_stop_sync};
        if (cpu_samp_reg[0] == cpu_stop_sync) begin
          cpu_stop_act_reg <= cpu_stop_sync;
        end
      end
      if (div_rise[2]) begin
        bus_stop_act_reg <= bus_stop_sync;
      end
    end
  end

  genvar r;
  generate
    for (r = 0; r < NREQ; r = r + 1) begin : g_req
      always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          req_samp_reg[2*r+1:2*r] <= 2'h0;
          req_act_reg[r]          <= 1'b0;
        end else if (clk_en && div_fall[1]) begin
          req_samp_reg[2*r+1:2*r] <= {req_samp_reg[2*r], req_sync[r]};
          if (req_samp_reg[2*r] == req_sync[r]) begin
            req_act_reg[r] <= req_sync[r];
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Differential outputs

  genvar i;
  generate
    for (i = 0; i < ND; i = i + 1) begin : g_diff
      localparam [0:0] IS_CPU = (i < NCPU);
      localparam D      = IS_CPU ? 0 : 1;
      localparam J      = IS_CPU ? 0 : i - NCPU;
      localparam C      = IS_CPU ? i : 0;
      wire cause_cpu = IS_CPU & cpu_stop_act_reg & cpu_stoppable[C];
      wire cause_bus = ~IS_CPU & bus_stop_act_reg & ~link_free[J];
      wire cause_req = ~IS_CPU & req_src[J];
      wire stop_want = pwrdn_stop_reg | hold_all | cause_cpu | cause_bus | cause_req;
      wire hi_stop   = pwrdn_stop_reg | (cause_req & ~req_mode);
      wire park      = IS_CPU ? cpu_tristate[C] : 1'b1;
      reg  [3:0] drv;
      always @* begin
        if (diff_run_reg[i]) begin
          drv = {div_ph[D], 1'b1, ~div_ph[D], 1'b1};
        end else if (pwrdn_stop_reg) begin
          drv = {1'b1, ~pwrdn_mode[i], 1'b0, 1'b0};
        end else if (cause_cpu) begin
          drv = 4'h0;
        end else if (cause_req) begin
          drv = req_mode ? 4'h0 : 4'hf & {1'b1, 1'b1, 1'b0, 1'b1};
        end else if (cause_bus) begin
          drv = 4'h0;
        end else if (park) begin
          drv = 4'hd;
        end else begin
          drv = 4'h0;
        end
      end
      always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          diff_run_reg[i] <= 1'b0;
          diff_true[i]    <= 1'b0;
          diff_true_oe[i] <= 1'b0;
          diff_comp[i]    <= 1'b0;
          diff_comp_oe[i] <= 1'b0;
        end else if (clk_en) begin
          if (diff_run_reg[i] & stop_want & (hi_stop ? div_rise[D] : div_fall[D])) begin
            diff_run_reg[i] <= 1'b0;
          end else if (~diff_run_reg[i] & ~stop_want & div_rise[D]) begin
            diff_run_reg[i] <= 1'b1;
          end
          diff_true[i]    <= drv[3];
          diff_true_oe[i] <= drv[2];
          diff_comp[i]    <= drv[1];
          diff_comp_oe[i] <= drv[0];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Single-ended bus clocks

  genvar m;
  generate
    for (m = 0; m < NBUS; m = m + 1) begin : g_bus
      wire free      = (m < NFREE) ? bus_free[(m < NFREE) ? m : 0] : 1'b0;
      wire stop_want = pwrdn_stop_reg | hold_all | (bus_stop_act_reg & ~free);
      always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          bus_run_reg[m] <= 1'b0;
          bus_clk[m]     <= 1'b0;
        end else if (clk_en) begin
          if (bus_run_reg[m] & stop_want & div_fall[2]) begin
            bus_run_reg[m] <= 1'b0;
          end else if (~bus_run_reg[m] & ~stop_want & div_rise[2]) begin
            bus_run_reg[m] <= 1'b1;
          end
          bus_clk[m] <= bus_run_reg[m] & div_ph[2];
        end
      end
    end
  endgenerate

endmodule

// File: tb/csp_clock_stop_ctrl_properties.sv
module csp_props #(
  parameter NCPU = 2,
  parameter NSRC = 6,
  parameter NBUS = 6
) (
  input wire logic                 clk_sys,
  input wire logic                 arst_n,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pslverr,
  input wire logic                 processor_clock_stop_n,
  input wire logic                 bus_clock_stop_n,
  input wire logic                 osc_enable,
  input wire logic [NCPU+NSRC-1:0] diff_true,
  input wire logic [NCPU+NSRC-1:0] diff_true_oe,
  input wire logic [NCPU+NSRC-1:0] diff_comp,
  input wire logic [NCPU+NSRC-1:0] diff_comp_oe,
  input wire logic [NBUS-1:0]      bus_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] cpu_cnt_reg;
  logic [5:0] bus_cnt_reg;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  // Cycles a stop request has been held while the oscillator runs
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cpu_cnt_reg <= 6'h00;
      bus_cnt_reg <= 6'h00;
    end else begin
      cpu_cnt_reg <= (processor_clock_stop_n || !osc_enable) ? 6'h00
                     : cpu_cnt_reg + {5'h00, cpu_cnt_reg != 6'h3f};
      bus_cnt_reg <= (bus_clock_stop_n || !osc_enable) ? 6'h00
                     : bus_cnt_reg + {5'h00, bus_cnt_reg != 6'h3f};
    end
  end

  a_comp_needs_true: assert property ((diff_comp_oe & ~diff_true_oe) == '0)
    else $error("complement driven while true line floats");
  a_pair_opposite: assert property ((diff_true_oe & diff_comp_oe & ~(diff_true ^ diff_comp)) == '0)
    else $error("driven pair not complementary");
  a_lone_true_high: assert property ((diff_true_oe & ~diff_comp_oe & ~diff_true) == '0)
    else $error("lone driven true line not high");
  a_off_bus_low: assert property (!osc_enable |-> bus_clk == '0)
    else $error("bus clock not low with oscillator off");
  a_err_access: assert property (pslverr |-> psel && penable)
    else $error("error response outside access phase");
  a_cpu_stop_sync: assert property ($fell(processor_clock_stop_n) && osc_enable
    |=> $stable(diff_true_oe[NCPU-1:0]) [*2])
    else $error("processor stop acted before synchronizer");
  a_cpu_stop_bound: assert property (cpu_cnt_reg == 6'd24 |->
    diff_true_oe[NCPU-1:0] == '0 && diff_comp_oe[NCPU-1:0] == '0)
    else $error("processor outputs not stopped in time");
  a_bus_stop_bound: assert property (bus_cnt_reg == 6'd40 |-> bus_clk[NBUS-1:2] == '0)
    else $error("bus clocks not latched low in time");

  cover property ($fell(osc_enable));
  cover property (cpu_cnt_reg == 6'd24);
  cover property ($rose(pslverr));
endmodule

bind csp_clock_stop_ctrl csp_props #(.NCPU(NCPU), .NSRC(NSRC), .NBUS(NBUS)) u_props (
  .clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable), .pslverr(pslverr),
  .processor_clock_stop_n(processor_clock_stop_n), .bus_clock_stop_n(bus_clock_stop_n),
  .osc_enable(osc_enable), .diff_true(diff_true), .diff_true_oe(diff_true_oe),
  .diff_comp(diff_comp), .diff_comp_oe(diff_comp_oe), .bus_clk(bus_clk));

// File: tb/csp_chipset_model.sv
module csp_chipset_model (
  input wire logic   clk_sys,
  output logic       supply_good_strobe_n,
  output logic       processor_clock_stop_n,
  output logic       bus_clock_stop_n,
  output logic [1:0] clock_request_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // Supply not yet good, no stop requests
  initial {supply_good_strobe_n, processor_clock_stop_n, bus_clock_stop_n, clock_request_n} = 5'h1f;

  // Pins change just after a rising edge; lag models a slow chipset
  task automatic drive(input logic [4:0] pins, input int lag);
    repeat (lag) @(posedge clk_sys);
    @(posedge clk_sys);
    {supply_good_strobe_n, processor_clock_stop_n, bus_clock_stop_n, clock_request_n} <= pins;
  endtask
endmodule

// File: tb/csp_testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, sup_n, cpu_n, bus_n, osc_enable, vco_enable;
  logic [1:0]  req_n;
  logic [7:0]  diff_true, diff_true_oe, diff_comp, diff_comp_oe, dt;
  logic [5:0]  bus_clk, db;
  int          failures = 0, check_count = 0, i, m;

  always #4 clk_sys = ~clk_sys;

  csp_chipset_model u_chip (.clk_sys(clk_sys), .supply_good_strobe_n(sup_n),
    .processor_clock_stop_n(cpu_n), .bus_clock_stop_n(bus_n), .clock_request_n(req_n));
  csp_clock_stop_ctrl #(.LOCK_CYC(18'd20)) uut (.clk_sys(clk_sys), .arst_n(arst_n),
    .clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .supply_good_strobe_n(sup_n), .processor_clock_stop_n(cpu_n),
    .bus_clock_stop_n(bus_n), .clock_request_n(req_n), .osc_enable(osc_enable),
    .vco_enable(vco_enable), .diff_true(diff_true), .diff_true_oe(diff_true_oe),
    .diff_comp(diff_comp), .diff_comp_oe(diff_comp_oe), .bus_clk(bus_clk));

  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, rd, e);
  endtask

  // Collects which lines toggled over n cycles
  task automatic toggles(input int n);
    logic [7:0] pt;
    logic [5:0] pb;
    @(posedge clk_sys);
    pt = diff_true; pb = bus_clk; dt = 8'h00; db = 6'h00;
    repeat (n) begin
      @(posedge clk_sys);
      dt |= pt ^ diff_true; db |= pb ^ bus_clk; pt = diff_true; pb = bus_clk;
    end
  endtask

  task automatic wait_run();
    rd = 32'h0;
    for (i = 0; i < 40 && rd[2] !== 1'b1; i++) apb(1'b0, 8'h0c, 32'h0);
  endtask

  task automatic summarize();
    if (failures == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #400000;
    failures++;
    summarize();
  end

  initial begin
    repeat (16) @(posedge clk_sys);
    chk("reset osc", {vco_enable, osc_enable, diff_true_oe}, 10'h300);
    arst_n <= 1'b1;
    rchk("down mode", 8'h00, 32'h0);
    rchk("cpu cfg", 8'h04, 32'h3);
    rchk("bus cfg", 8'h08, 32'h0);
    rchk("map0", 8'h28, 32'h0);
    rchk("boot", 8'h0c, 32'h21);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped", {31'h0, err}, 32'h1);
    chk("unmapped rd", rd, 32'h0);
    apb(1'b1, 8'h28, 32'h1);
    apb(1'b1, 8'h2c, 32'h2);
    rchk("map1", 8'h2c, 32'h2);
    u_chip.drive(5'b01111, 0);
    wait_run();
    chk("run", rd[4:0], 5'h04);
    toggles(16);
    chk("all run", {dt, db}, 14'h3fff);
    u_chip.drive(5'b00111, 3);
    repeat (30) @(posedge clk_sys);
    chk("cpu stop", {diff_true_oe[1:0], diff_comp_oe[1:0]}, 4'h0);
    rchk("cpu st", 8'h0c, 32'h3ffc_0064);
    u_chip.drive(5'b01111, 0);
    repeat (24) @(posedge clk_sys);
    toggles(8);
    chk("cpu go", {dt[1:0], diff_true_oe[1:0]}, 4'hf);
    apb(1'b1, 8'h08, 32'h1);
    u_chip.drive(5'b01011, 0);
    repeat (40) @(posedge clk_sys);
    toggles(16);
    chk("bus stop", {db, diff_true_oe[7:2]}, 12'h040);
    u_chip.drive(5'b01111, 0);
    for (i = 0; i < 12 && diff_true_oe[7:2] !== 6'h3f; i++) @(posedge clk_sys);
    chk("link park", {diff_true_oe[7:2], diff_true[7:2]}, 12'hfff);
    repeat (16) @(posedge clk_sys);
    toggles(16);
    chk("bus go", {db, dt[7:2]}, 12'hfff);
    for (m = 0; m < 2; m++) begin
      apb(1'b1, 8'h08, {15'h0, m[0], 16'h0});
      u_chip.drive(5'b01110, 0);
      u_chip.drive(5'b01111, 0);
      repeat (12) @(posedge clk_sys);
      rchk("glitch", 8'h0c, 32'h3fff_0024);
      u_chip.drive(5'b01100, 0);
      repeat (40) @(posedge clk_sys);
      toggles(16);
      chk("req oe", {diff_true_oe[3:2], diff_comp_oe[3:2]}, m ? 4'h0 : 4'hf);
      if (m == 0) chk("req lvl", {diff_true[3:2], diff_comp[3:2]}, 4'hc);
      chk("req map", dt[7:2], 6'h3c);
      apb(1'b0, 8'h0c, 32'h0);
      chk("req st", rd[9:8], 2'b11);
      u_chip.drive(5'b01111, 0);
      for (i = 0; i < 12 && diff_true_oe[3:2] !== 2'b11; i++) @(posedge clk_sys);
      chk("req park", diff_true_oe[3:2], 2'b11);
      repeat (24) @(posedge clk_sys);
      toggles(16);
      chk("req go", dt[3:2], 2'b11);
    end
    apb(1'b1, 8'h08, 32'h0);
    apb(1'b1, 8'h00, 32'hfc);
    u_chip.drive(5'b11111, 0);
    for (i = 0; i < 200 && osc_enable !== 1'b0; i++) @(posedge clk_sys);
    chk("down osc", {vco_enable, osc_enable, bus_clk}, 8'h00);
    chk("down diff", {diff_true_oe, diff_comp_oe, diff_true[1:0]}, 18'h00c03);
    rchk("off", 8'h0c, 32'h10);
    u_chip.drive(5'b01111, 0);
    wait_run();
    chk("wake", rd[4:0], 5'h04);
    for (i = 0; i < 20 && diff_true_oe !== 8'hff; i++) @(posedge clk_sys);
    chk("wake oe", diff_true_oe, 8'hff);
    toggles(16);
    chk("wake run", {dt, db}, 14'h3fff);
    summarize();
  end
endmodule
